// ===== hdl/dma_engine.sv
// five-channel dma engine with ahb-lite register slave and one ram port
// assumes the ram arbiter answers each request with a one-cycle ack,
// read data valid with that ack; peripheral triggers are async pins
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dma_engine_defines.svh"
// Overview of operation
// [RULE1] three directions: mem-mem, mem-per, per-mem
// [RULE2] five channels, bursts of eight beats
// [RULE3] only one channel moves data
// [RULE4] per-channel selectable trigger source
// [RULE5] half-point and complete flag per channel
// [RULE6] beat width follows trigger type
// [RULE7] ram access through shared arbiter handshake
// [RULE8] any ram address usable either side
// [RULE9] lowest pending channel wins, holds burst
// [RULE10] sticky flags, write-one clear, level irq
module dma_engine import dma_engine_pkg::*; #(
    parameter int NCH   = `DMA_NUM_CH,
    parameter int BURST = `DMA_BURST_LEN
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic [8:1]  TRIG_PINS,
    output logic             RAM_REQ,
    output logic             RAM_WR,
    output logic      [1:0]  RAM_SIZE,
    output logic      [31:0] RAM_ADDR,
    output logic      [31:0] RAM_WDATA,
    input  wire logic        RAM_ACK,
    input  wire logic [31:0] RAM_RDATA,
    output logic             IRQ
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_NEXT  = 4'b1000
    } st_t;

    typedef struct packed {
        chan_t [NCH-1:0]  ch;
        logic [2*NCH-1:0] stat;
        logic [2*NCH-1:0] ien;
        logic [NCH-1:0]   act;
        logic [3:0]       beat;
        logic [31:0]      buf_w;
        st_t              st;
        logic [8:1]       t1;
        logic [8:1]       t2;
        logic             ap_v;
        logic             ap_w;
        logic [11:0]      ap_a;
        logic [31:0]      rdata;
        ram_req_t         ram;
        logic             irq;
    } state_t;

    state_t s_r, s_nxt;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] grant;
    int             cur;

    // beat size in bytes, log2, per trigger source
    function automatic logic [1:0] beat_size(input trig_t t);
        unique case (t)
            TRG_SER_RX, TRG_SER_TX:             beat_size = 2'h0; // RULE6
            TRG_AUD_IN, TRG_AUD_SER, TRG_AUD_OUT: beat_size = 2'h1; // RULE6
            default:                            beat_size = 2'h2; // RULE6
        endcase
    endfunction : beat_size

    function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] sz);
        step = a + (32'h0000_0001 << sz);
    endfunction : step

    function automatic int chan_of(input logic [NCH-1:0] v);
        chan_of = 0;
        for (int i = 0; i < NCH; i++) begin
            if (v[i]) begin
                chan_of = i;
            end
        end
    endfunction : chan_of

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            // memory trigger is always ready; peripherals need their pin
            pend[i] = s_r.ch[i].en &&
                      (s_r.ch[i].trg == TRG_MEMORY || s_r.t2[s_r.ch[i].trg]); // RULE4
        end
    end

    dma_arbiter #(.N(NCH)) u_arb (
        .pend  (pend),
        .grant (grant)
    );

    assign cur = chan_of(s_r.act);

    always_comb begin
        logic [11:0] a;
        logic [1:0]  sz;
        int          ci;
        a  = 12'h000;
        sz = 2'h0;
        ci = 0;
        s_nxt = s_r;
        s_nxt.t1 = TRIG_PINS;
        s_nxt.t2 = s_r.t1;
        // ahb data phase of a write
        if (s_r.ap_v && s_r.ap_w) begin
            a = s_r.ap_a;
            if (a == `DMA_OFS_CLEAR) begin
                s_nxt.stat = s_r.stat & ~HWDATA[2*NCH-1:0]; // RULE10
            end else if (a == `DMA_OFS_ENABLE) begin
                s_nxt.ien = HWDATA[2*NCH-1:0];
            end else if (a >= `DMA_OFS_CH_BASE && a < 12'(`DMA_OFS_CH_BASE + NCH * `DMA_OFS_CH_STRIDE)) begin
                ci = int'((a - `DMA_OFS_CH_BASE) >> 4);
                unique case (a[3:2])
                    `DMA_CH_SRC: s_nxt.ch[ci].src = HWDATA; // RULE8
                    `DMA_CH_DST: s_nxt.ch[ci].dst = HWDATA; // RULE8
                    `DMA_CH_CNT: s_nxt.ch[ci].cnt = HWDATA[15:0];
                    `DMA_CH_CTL: begin
                        s_nxt.ch[ci].dir = dir_t'(HWDATA[`DMA_CTL_DIR_LSB +: 2]); // RULE1
                        s_nxt.ch[ci].trg = trig_t'(HWDATA[`DMA_CTL_TRG_LSB +: 4]); // RULE4
                        if (HWDATA[`DMA_CTL_START] && s_r.ch[ci].cnt != 16'h0000) begin
                            s_nxt.ch[ci].en = 1'b1;
                            s_nxt.ch[ci].left = s_r.ch[ci].cnt;
                            s_nxt.ch[ci].half_done = 1'b0;
                        end
                    end
                endcase
            end
        end
        // ahb address phase capture
        s_nxt.ap_v = HSEL && HREADY && HTRANS[1];
        s_nxt.ap_w = HWRITE;
        s_nxt.ap_a = HADDR[11:0];
        a = HADDR[11:0];
        s_nxt.rdata = `DMA_RESET_WORD;
        if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
            if (a == `DMA_OFS_GLOBAL) begin
                s_nxt.rdata = 32'(s_r.act);
            end else if (a == `DMA_OFS_STATUS) begin
                s_nxt.rdata = 32'(s_r.stat);
            end else if (a == `DMA_OFS_ENABLE) begin
                s_nxt.rdata = 32'(s_r.ien);
            end else if (a >= `DMA_OFS_CH_BASE && a < 12'(`DMA_OFS_CH_BASE + NCH * `DMA_OFS_CH_STRIDE)) begin
                ci = int'((a - `DMA_OFS_CH_BASE) >> 4);
                unique case (a[3:2])
                    `DMA_CH_SRC: s_nxt.rdata = s_r.ch[ci].src;
                    `DMA_CH_DST: s_nxt.rdata = s_r.ch[ci].dst;
                    `DMA_CH_CNT: s_nxt.rdata = {s_r.ch[ci].left, s_r.ch[ci].cnt};
                    `DMA_CH_CTL: s_nxt.rdata = {23'h00_0000, s_r.ch[ci].en, s_r.ch[ci].trg,
                                                1'b0, s_r.ch[ci].dir, 1'b0};
                endcase
            end
        end
        // transfer engine
        sz = beat_size(s_r.ch[cur].trg);
        unique case (s_r.st)
            ST_IDLE: begin
                if (|pend) begin
                    s_nxt.act  = grant; // RULE3 RULE9
                    s_nxt.beat = 4'h0;
                    s_nxt.st   = ST_READ;
                end
            end
            ST_READ: begin
                s_nxt.ram.req  = 1'b1; // RULE7
                s_nxt.ram.wr   = 1'b0;
                s_nxt.ram.size = sz;
                s_nxt.ram.addr = s_r.ch[cur].src;
                if (s_r.ram.req && RAM_ACK) begin
                    s_nxt.ram.req = 1'b0;
                    s_nxt.buf_w   = RAM_RDATA;
                    s_nxt.st      = ST_WRITE;
                end
            end
            ST_WRITE: begin
                s_nxt.ram.req   = 1'b1; // RULE7
                s_nxt.ram.wr    = 1'b1;
                s_nxt.ram.size  = sz;
                s_nxt.ram.addr  = s_r.ch[cur].dst;
                s_nxt.ram.wdata = s_r.buf_w;
                if (s_r.ram.req && RAM_ACK) begin
                    s_nxt.ram.req = 1'b0;
                    s_nxt.st      = ST_NEXT;
                end
            end
            ST_NEXT: begin
                // peripheral side keeps a fixed fifo address
                if (s_r.ch[cur].dir != DIR_PER2MEM) begin
                    s_nxt.ch[cur].src = step(s_r.ch[cur].src, sz); // RULE1
                end
                if (s_r.ch[cur].dir != DIR_MEM2PER) begin
                    s_nxt.ch[cur].dst = step(s_r.ch[cur].dst, sz); // RULE1
                end
                s_nxt.ch[cur].left = s_r.ch[cur].left - 16'h0001;
                s_nxt.beat = s_r.beat + 4'h1;
                if (!s_r.ch[cur].half_done && (s_r.ch[cur].left - 16'h0001) <= (s_r.ch[cur].cnt >> 1)) begin
                    s_nxt.ch[cur].half_done = 1'b1;
                    s_nxt.stat[cur] = 1'b1; // RULE5
                end
                if (s_r.ch[cur].left == 16'h0001) begin
                    s_nxt.ch[cur].en = 1'b0;
                    s_nxt.stat[NCH + cur] = 1'b1; // RULE5
                    s_nxt.act = '0;
                    s_nxt.st  = ST_IDLE;
                end else if (s_r.beat == 4'(BURST - 1)) begin
                    // burst boundary: re-arbitrate so a lower pending channel can take over
                    s_nxt.act = '0; // RULE2 RULE9
                    s_nxt.st  = ST_IDLE;
                end else begin
                    s_nxt.st = ST_READ;
                end
            end
        endcase
        // next enable too, so masking and unmasking reach the pin with the flags
        s_nxt.irq = |(s_nxt.stat & s_nxt.ien); // RULE10
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r    <= '0;
            s_r.st <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign HRDATA    = s_r.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign RAM_REQ   = s_r.ram.req;
    assign RAM_WR    = s_r.ram.wr;
    assign RAM_SIZE  = s_r.ram.size;
    assign RAM_ADDR  = s_r.ram.addr;
    assign RAM_WDATA = s_r.ram.wdata;
    assign IRQ       = s_r.irq;

    property p_onehot_act;
        @(posedge CLK) disable iff (!RESET_N) $onehot0(s_r.act);
    endproperty
    a_onehot_act: assert property (p_onehot_act) else $error("two channels active"); // RULE3

    property p_req_held;
        @(posedge CLK) disable iff (!RESET_N) RAM_REQ && !RAM_ACK |=> RAM_REQ && $stable(RAM_ADDR);
    endproperty
    a_req_held: assert property (p_req_held) else $error("ram request dropped"); // RULE7

    property p_irq_level;
        @(posedge CLK) disable iff (!RESET_N) IRQ == |(s_r.stat & s_r.ien);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not level of flags"); // RULE10

    property p_burst_len;
        @(posedge CLK) disable iff (!RESET_N) s_r.st != ST_IDLE |-> s_r.beat < 4'(BURST);
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst too long"); // RULE2

    property p_sticky;
        @(posedge CLK) disable iff (!RESET_N)
            s_r.stat[0] && !(s_r.ap_v && s_r.ap_w && s_r.ap_a == `DMA_OFS_CLEAR) |=> s_r.stat[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without clear"); // RULE10

    property p_grant_low;
        @(posedge CLK) disable iff (!RESET_N)
            s_r.st == ST_IDLE && pend[0] |=> s_r.act[0];
    endproperty
    a_grant_low: assert property (p_grant_low) else $error("channel zero not first"); // RULE9

    property p_width;
        @(posedge CLK) disable iff (!RESET_N)
            RAM_REQ && s_r.ch[cur].trg == TRG_SER_RX |-> RAM_SIZE == 2'h0;
    endproperty
    a_width: assert property (p_width) else $error("serial beat not byte"); // RULE6

    property p_done_flag;
        @(posedge CLK) disable iff (!RESET_N)
            s_r.st == ST_NEXT && s_r.ch[cur].left == 16'h0001 |=> s_r.stat[NCH + $past(cur)];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag missing"); // RULE5

    property p_grant_hold;
        @(posedge CLK) disable iff (!RESET_N)
            s_r.st == ST_NEXT && s_r.beat != 4'(BURST - 1) && s_r.ch[cur].left != 16'h0001 |=> $stable(s_r.act);
    endproperty
    a_grant_hold: assert property (p_grant_hold) else $error("grant moved inside a burst"); // RULE9

    property p_width_audio;
        @(posedge CLK) disable iff (!RESET_N)
            RAM_REQ && (s_r.ch[cur].trg == TRG_AUD_IN || s_r.ch[cur].trg == TRG_AUD_SER ||
                        s_r.ch[cur].trg == TRG_AUD_OUT) |-> RAM_SIZE == 2'h1;
    endproperty
    a_width_audio: assert property (p_width_audio) else $error("audio beat not halfword"); // RULE6
endmodule : dma_engine
`default_nettype wire

// ===== hdl/dma_engine_defines.svh
// register offsets, field positions, reset values and counts for the dma engine
// assumes byte addressing on a 32-bit ahb-lite bus
`ifndef DMA_ENGINE_DEFINES_SVH
`define DMA_ENGINE_DEFINES_SVH
`define DMA_NUM_CH        5
`define DMA_BURST_LEN     8
`define DMA_OFS_GLOBAL    12'h000
`define DMA_OFS_STATUS    12'h004
`define DMA_OFS_CLEAR     12'h008
`define DMA_OFS_ENABLE    12'h00C
`define DMA_OFS_CH_BASE   12'h010
`define DMA_OFS_CH_STRIDE 12'h010
`define DMA_CH_SRC        2'h0
`define DMA_CH_DST        2'h1
`define DMA_CH_CNT        2'h2
`define DMA_CH_CTL        2'h3
`define DMA_CTL_START     0
`define DMA_CTL_DIR_LSB   1
`define DMA_CTL_TRG_LSB   4
`define DMA_CTL_BUSY      8
`define DMA_STAT_DONE_LSB 5
`define DMA_RESET_WORD    32'h0000_0000
`endif

// ===== hdl/dma_engine_pkg.sv
// types shared by the dma engine files
// assumes the defines header is compiled alongside
package dma_engine_pkg;
    typedef enum logic [1:0] {
        DIR_MEM2MEM = 2'h0,
        DIR_MEM2PER = 2'h1,
        DIR_PER2MEM = 2'h2
    } dir_t;
    typedef enum logic [3:0] {
        TRG_MEMORY   = 4'h0,
        TRG_BB_TX    = 4'h1,
        TRG_BB_RX    = 4'h2,
        TRG_MODEM    = 4'h3,
        TRG_SER_RX   = 4'h4,
        TRG_SER_TX   = 4'h5,
        TRG_AUD_IN   = 4'h6,
        TRG_AUD_SER  = 4'h7,
        TRG_AUD_OUT  = 4'h8
    } trig_t;
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] cnt;
        logic [15:0] left;
        logic        en;
        logic        half_done;
        dir_t        dir;
        trig_t       trg;
    } chan_t;
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ram_req_t;
endpackage : dma_engine_pkg

// ===== hdl/dma_arbiter.sv
// fixed-priority channel picker, lowest index wins
// assumes pending vector is registered in the caller
`timescale 1ns/10ps
`default_nettype none
module dma_arbiter #(
    parameter int N = 5
) (
    input  wire logic [N-1:0] pend,
    output var  logic [N-1:0] grant
);
    always_comb begin
        grant = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                grant = '0;
                grant[i] = 1'b1; // RULE9
            end
        end
    end
endmodule : dma_arbiter
`default_nettype wire

// ===== test/dma_ram_model.sv
// behavioural ram arbiter and memory behind the dma ram port
// assumes one-cycle ack, read data valid only in the ack cycle
`timescale 1ns/10ps
`default_nettype none
module dma_ram_model (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        SLOW,
    input  wire logic        RAM_REQ,
    input  wire logic        RAM_WR,
    input  wire logic [1:0]  RAM_SIZE,
    input  wire logic [31:0] RAM_ADDR,
    input  wire logic [31:0] RAM_WDATA,
    output var  logic        RAM_ACK,
    output var  logic [31:0] RAM_RDATA
);
    logic [31:0] mem [int unsigned];
    logic [31:0] addr_q [$];
    logic [1:0]  size_last;
    int          wait_r;
    function automatic logic [31:0] peek(input logic [31:0] a);
        return mem.exists(a[31:2]) ? mem[a[31:2]] : ~a;
    endfunction : peek
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RAM_ACK   <= 1'b0;
            RAM_RDATA <= 32'h0000_0000;
            wait_r    <= 0;
        end else begin
            RAM_RDATA <= $urandom; // junk outside the ack cycle
            RAM_ACK   <= 1'b0;
            if (RAM_REQ && !RAM_ACK && wait_r == 0) begin
                RAM_ACK <= 1'b1;
                wait_r  <= SLOW ? int'($urandom_range(4, 1)) : 0; // processor holds the ram
                addr_q.push_back(RAM_ADDR);
                if (RAM_WR) begin
                    mem[RAM_ADDR[31:2]] = RAM_WDATA;
                    size_last <= RAM_SIZE;
                end else begin
                    RAM_RDATA <= peek(RAM_ADDR);
                end
            end else if (RAM_REQ && wait_r != 0) begin
                wait_r <= wait_r - 1;
            end
        end
    end
endmodule : dma_ram_model
`default_nettype wire

// ===== test/five_channel_dma_engine_tb_top.sv
// self-checking bench for the five-channel dma engine
// assumes dma_ram_model on the ram port, this module as the only ahb master
`timescale 1ns/10ps
`default_nettype none
`include "dma_engine_defines.svh"
module five_channel_dma_engine_tb_top import dma_engine_pkg::*;;
    logic        CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic        HWRITE = 1'b0;
    logic        SLOW = 1'b0;
    logic [1:0]  HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0000_0000;
    logic [31:0] HWDATA = 32'h0000_0000;
    logic [8:1]  TRIG_PINS = 8'h00;
    logic [31:0] HRDATA, RAM_ADDR, RAM_WDATA, RAM_RDATA, rd;
    logic        HREADYOUT, HRESP, RAM_REQ, RAM_WR, RAM_ACK, IRQ;
    logic [1:0]  RAM_SIZE;
    int          err_total = 0;
    int          compares = 0;
    always #50 CLK = ~CLK;
    dma_engine i_dma_engine (.CLK(CLK), .RESET_N(RESET_N), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TRIG_PINS(TRIG_PINS), .RAM_REQ(RAM_REQ), .RAM_WR(RAM_WR),
        .RAM_SIZE(RAM_SIZE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA), .RAM_ACK(RAM_ACK),
        .RAM_RDATA(RAM_RDATA), .IRQ(IRQ));
    dma_ram_model i_dma_ram_model (.CLK(CLK), .RESET_N(RESET_N), .SLOW(SLOW), .RAM_REQ(RAM_REQ),
        .RAM_WR(RAM_WR), .RAM_SIZE(RAM_SIZE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
        .RAM_ACK(RAM_ACK), .RAM_RDATA(RAM_RDATA));
    task automatic stop_test();
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic hold();
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            stop_test();
        end
    endtask : hold
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        HADDR  <= {20'h0_0000, a};
        HWRITE <= w;
        HTRANS <= 2'h2;
        hold();
        HTRANS <= 2'h0;
        HWDATA <= d;
        hold();
        rd = HRDATA;
    endtask : bus
    task automatic read_is(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, '0);
        chk(rd, e);
    endtask : read_is
    function automatic logic [11:0] cb(input int ch, input logic [1:0] r);
        return `DMA_OFS_CH_BASE + `DMA_OFS_CH_STRIDE * 12'(ch) + {8'h00, r, 2'b00};
    endfunction : cb
    function automatic logic [1:0] width_of(input int t);
        if (t == 4 || t == 5) return 2'h0;
        if (t >= 6) return 2'h1;
        return 2'h2;
    endfunction : width_of
    task automatic run(input int ch, input logic [31:0] s, input logic [31:0] d, input int n, input int dir,
                       input int t);
        bus(1'b1, cb(ch, `DMA_CH_SRC), s);
        bus(1'b1, cb(ch, `DMA_CH_DST), d);
        bus(1'b1, cb(ch, `DMA_CH_CNT), 32'(n));
        bus(1'b1, cb(ch, `DMA_CH_CTL), 32'((t << 4) | (dir << 1) | 1));
    endtask : run
    task automatic idle(input int ch);
        int k;
        for (k = 0; k < 300; k++) begin
            bus(1'b0, `DMA_OFS_GLOBAL, '0);
            chk(32'($onehot0(rd[4:0])), 32'h0000_0001);
            bus(1'b0, cb(ch, `DMA_CH_CTL), '0);
            if (rd[`DMA_CTL_BUSY] === 1'b0) break;
        end
        if (k == 300) begin
            err_total++;
            stop_test();
        end
    endtask : idle
    task automatic irq_is(input logic e);
        @(negedge CLK);
        chk({31'h0, IRQ}, {31'h0, e});
        @(posedge CLK);
    endtask : irq_is
    // status must hold half and done of one channel; cleared by writing ones
    task automatic flags(input int ch);
        read_is(`DMA_OFS_STATUS, 32'h0000_0021 << ch);
        irq_is(1'b1);
        bus(1'b1, `DMA_OFS_CLEAR, 32'h0000_0021 << ch);
        read_is(`DMA_OFS_STATUS, 32'h0000_0000);
        irq_is(1'b0);
    endtask : flags
    initial begin
        repeat (90000) @(posedge CLK);
        err_total++;
        stop_test();
    end
    initial begin
        int          ch, n, t;
        logic [31:0] s, d;
        void'($urandom(32'ha41b_3e26));
        repeat (5) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        read_is(`DMA_OFS_GLOBAL, 32'h0000_0000);
        read_is(`DMA_OFS_STATUS, 32'h0000_0000);
        read_is(`DMA_OFS_ENABLE, 32'h0000_0000);
        read_is(12'h800, 32'h0000_0000);
        chk({31'h0, HRESP}, 32'h0000_0000);
        chk({31'h0, HREADYOUT}, 32'h0000_0001);
        irq_is(1'b0);
        bus(1'b1, `DMA_OFS_ENABLE, 32'h0000_03FF);
        read_is(`DMA_OFS_ENABLE, 32'h0000_03FF);
        // random copies of one to twenty beats, up to two eight-beat burst edges, fast and slow ram
        for (ch = 0; ch < 5; ch++) begin
            SLOW <= ch[0];
            n = int'($urandom_range(20, 1));
            s = 32'h0000_1000 + ($urandom_range(255) << 2);
            d = 32'h0000_8000 + ($urandom_range(255) << 2);
            i_dma_ram_model.addr_q.delete();
            run(ch, s, d, n, DIR_MEM2MEM, TRG_MEMORY);
            idle(ch);
            chk(32'(i_dma_ram_model.addr_q.size()), 32'(2 * n));
            for (t = 0; t < n; t++) chk(i_dma_ram_model.peek(d + 4 * t), ~(s + 4 * t));
            flags(ch);
        end
        // masked source keeps irq low until enabled again
        bus(1'b1, `DMA_OFS_ENABLE, 32'h0000_0000);
        run(2, 32'h0000_1000, 32'h0000_9000, 1, DIR_MEM2MEM, TRG_MEMORY);
        idle(2);
        irq_is(1'b0);
        bus(1'b1, `DMA_OFS_ENABLE, 32'h0000_03FF);
        flags(2);
        // every peripheral source, beat width of the write side
        TRIG_PINS <= 8'hFF;
        for (t = 1; t < 9; t++) begin
            run(3, 32'h0000_2000, 32'h0000_F000, 2, DIR_MEM2PER, t);
            idle(3);
            chk(i_dma_ram_model.addr_q[$], 32'h0000_F000);
            chk(32'(i_dma_ram_model.size_last), 32'(width_of(t)));
            flags(3);
        end
        // two channels armed on a quiet source, then released together
        TRIG_PINS <= 8'h00;
        run(1, 32'h0000_F100, 32'h0000_3000, 2, DIR_PER2MEM, TRG_MODEM);
        run(0, 32'h0000_F000, 32'h0000_2000, 2, DIR_PER2MEM, TRG_MODEM);
        i_dma_ram_model.addr_q.delete();
        TRIG_PINS <= 8'h04;
        idle(0);
        idle(1);
        chk(i_dma_ram_model.addr_q[0], 32'h0000_F000);
        chk(i_dma_ram_model.addr_q[4], 32'h0000_F100);
        read_is(`DMA_OFS_STATUS, 32'h0000_0063);
        stop_test();
    end
endmodule : five_channel_dma_engine_tb_top
`default_nettype wire
